//--- spi_cmd_pkg.sv
// Constants, command codes and frame layout for the serial register access block
package spi_cmd_pkg;
	localparam int FRAME_BITS = 16;              // Bits per frame
	localparam int CNT_W      = 5;               // Clock pulse counter width
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F; // Counter saturates here
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10; // Pulses in a good frame
	localparam int CMD_W      = 4;               // Command field width
	localparam int ADDR_W     = 4;               // Address field width
	localparam int DATA_W     = 8;               // Register data width
	localparam int NUM_REGS   = 16;              // Registers per bank

	// Command codes
	localparam logic [CMD_W-1:0] CMD_CHECK    = 4'h0;
	localparam logic [CMD_W-1:0] CMD_RD_CFG   = 4'h1;
	localparam logic [CMD_W-1:0] CMD_WR_CFG   = 4'h2;
	localparam logic [CMD_W-1:0] CMD_RD_STAT  = 4'h3;
	localparam logic [CMD_W-1:0] CMD_WR_STAT  = 4'h4;
	localparam logic [CMD_W-1:0] CMD_RD_CTL   = 4'h5;
	localparam logic [CMD_W-1:0] CMD_WR_CTL   = 4'h6;
	localparam logic [CMD_W-1:0] CMD_CHK_RESP = 4'h7;

	// Integrity check answer: top bit low, next three high
	localparam logic       CHECK_TOP  = 1'h0;
	localparam logic [2:0] CHECK_FLIP = 3'h7;

	// Supply and fault status register
	localparam logic [ADDR_W-1:0] STATUS_ADDR  = 4'hD;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam int                STAT_ANY     = 7;     // Any-fault summary
	localparam int                STAT_SERIAL  = 3;     // Serial error
	localparam logic [DATA_W-1:0] FAULT_MASK   = 8'h77; // Bits fed by fault_in

	// Default of configuration and control registers
	localparam logic [DATA_W-1:0] BANK_RESET = 8'h00;

	// Self-test write enable lives in a control register
	localparam logic [ADDR_W-1:0] SELF_TEST_ADDR = 4'h0;
	localparam int                SELF_TEST_BIT  = 0;

	// One received frame
	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} frame_s;
endpackage : spi_cmd_pkg

//--- spi_frame_shifter.sv
// Pin synchronisers, shift registers and pulse counter of the serial link
`timescale 1ns/1ns
module spi_frame_shifter (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       sclk,
	input  wire logic                       frame_select_n,
	input  wire logic                       si,
	input  wire logic [spi_cmd_pkg::FRAME_BITS-1:0] tx_word,
	output logic                            so_out,
	output logic                            so_oe,
	output spi_cmd_pkg::frame_s             rx_frame,
	output logic                            frame_ok,
	output logic                            frame_bad
);
	import spi_cmd_pkg::*;

	logic [2:0]            sclk_q;      // Stage 0/1 synchroniser, 2 edge memory
	logic [2:0]            sel_q;       // Same for select
	logic [1:0]            si_q;        // Data synchroniser
	logic [FRAME_BITS-1:0] rx_sh;       // Incoming shift register
	logic [FRAME_BITS-1:0] tx_sh;       // Outgoing shift register
	logic [CNT_W-1:0]      count;       // Rising clock pulses this frame
	logic [FRAME_BITS-1:0] next_rx_sh;
	logic [FRAME_BITS-1:0] next_tx_sh;
	logic [CNT_W-1:0]      next_count;
	logic                  next_so_out;
	logic                  next_so_oe;
	frame_s                next_rx_frame;
	logic                  next_frame_ok;
	logic                  next_frame_bad;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  sel_fall;
	logic                  sel_rise;
	logic                  active;

	// Edges are only taken from the second stage onward
	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign sel_fall  = ~sel_q[1] & sel_q[2];
	assign sel_rise  = sel_q[1] & ~sel_q[2];
	assign active    = ~sel_q[1];

	// Synchronisers; select idles high so it resets high
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q <= 3'h0;
			sel_q  <= 3'h7;
			si_q   <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk};
			sel_q  <= {sel_q[1:0], frame_select_n};
			si_q   <= {si_q[0], si};
		end
	end

	// Shifting and framing
	always_comb begin
		next_rx_sh     = rx_sh;
		next_tx_sh     = tx_sh;
		next_count     = count;
		next_so_out    = so_out;
		next_so_oe     = so_oe;
		next_rx_frame  = rx_frame;
		next_frame_ok  = 1'b0;
		next_frame_bad = 1'b0;
		if (sel_fall) begin
			// Answer word is captured as the frame opens
			next_count  = '0;
			next_tx_sh  = tx_word;
			next_so_out = tx_word[FRAME_BITS-1];
			next_so_oe  = 1'b1;
		end else if (sel_rise) begin
			// Frame ends; only a full count is handed on
			next_so_oe  = 1'b0;
			next_so_out = 1'b0;
			if (count == CNT_FULL) begin
				next_frame_ok = 1'b1;
				next_rx_frame = rx_sh;
			end else begin
				next_frame_bad = 1'b1;
			end
		end else if (active) begin
			if (sclk_rise) begin
				// Sample on rising edge, MSB first
				next_rx_sh = {rx_sh[FRAME_BITS-2:0], si_q[1]};
				if (count != CNT_MAX) begin
					next_count = count + 1'b1;
				end
			end
			if (sclk_fall) begin
				// Output moves on falling edge
				next_so_out = tx_sh[FRAME_BITS-2];
				next_tx_sh  = {tx_sh[FRAME_BITS-2:0], 1'b0};
			end
		end
	end

	// Framing state registers
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_sh     <= '0;
			tx_sh     <= '0;
			count     <= '0;
			so_out    <= 1'b0;
			so_oe     <= 1'b0;
			rx_frame  <= '0;
			frame_ok  <= 1'b0;
			frame_bad <= 1'b0;
		end else begin
			rx_sh     <= next_rx_sh;
			tx_sh     <= next_tx_sh;
			count     <= next_count;
			so_out    <= next_so_out;
			so_oe     <= next_so_oe;
			rx_frame  <= next_rx_frame;
			frame_ok  <= next_frame_ok;
			frame_bad <= next_frame_bad;
		end
	end

	full_count_a: assert property (@(posedge clk) disable iff (rst)
		frame_ok |-> count == CNT_FULL)
		else $error("frame accepted without sixteen pulses");

	msb_first_a: assert property (@(posedge clk) disable iff (rst)
		sel_fall |=> so_oe && so_out == $past(tx_word[FRAME_BITS-1]))
		else $error("first output bit is not the answer MSB");
endmodule : spi_frame_shifter

//--- spi_command_regs.sv
// Serial command decoder with configuration, control and status register banks
`timescale 1ns/1ns
module spi_command_regs (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        sclk,
	input  wire logic                        frame_select_n,
	input  wire logic                        si,
	input  wire logic [spi_cmd_pkg::DATA_W-1:0] fault_in,
	output logic                             so_out,
	output logic                             so_oe,
	output logic [spi_cmd_pkg::NUM_REGS-1:0][spi_cmd_pkg::DATA_W-1:0] config_out,
	output logic [spi_cmd_pkg::NUM_REGS-1:0][spi_cmd_pkg::DATA_W-1:0] control_out,
	output logic [spi_cmd_pkg::DATA_W-1:0]   status_out
);
	import spi_cmd_pkg::*;

	typedef enum logic [0:0] {
		WAIT_FRAME,
		EXECUTE
	} exec_e;

	exec_e                 state;       // Decoder state
	exec_e                 next_state;
	frame_s                cmd_q;       // Frame under execution
	frame_s                next_cmd_q;
	frame_s                rx_frame;    // Frame from the shifter
	logic                  frame_ok;    // Full frame ended
	logic                  frame_bad;   // Frame with wrong pulse count
	logic [FRAME_BITS-1:0] resp;        // Word shifted out next frame
	logic [FRAME_BITS-1:0] next_resp;
	logic [NUM_REGS-1:0][DATA_W-1:0] next_cfg;
	logic [NUM_REGS-1:0][DATA_W-1:0] next_ctl;
	logic [DATA_W-1:0]     next_status;
	logic                  decode_err;  // Command or address unknown
	logic                  self_test;   // Status bits freely writable
	logic                  is_stat;     // Address names the status register

	assign self_test = control_out[SELF_TEST_ADDR][SELF_TEST_BIT];
	assign is_stat   = cmd_q.addr == STATUS_ADDR;

	// Link side: synchronising, shifting, counting
	spi_frame_shifter u_shifter (
		.clk            (clk),
		.rst            (rst),
		.sclk           (sclk),
		.frame_select_n (frame_select_n),
		.si             (si),
		.tx_word        (resp),
		.so_out         (so_out),
		.so_oe          (so_oe),
		.rx_frame       (rx_frame),
		.frame_ok       (frame_ok),
		.frame_bad      (frame_bad)
	);

	// Decode and register update; frames only arrive whole, so no
	// partial data can ever reach the banks
	always_comb begin
		next_state  = state;
		next_cmd_q  = cmd_q;
		next_resp   = resp;
		next_cfg    = config_out;
		next_ctl    = control_out;
		next_status = status_out;
		decode_err  = 1'b0;
		case (state)
			WAIT_FRAME: begin
				// A whole frame is taken when it ends
				// Only whole frames pulse frame_ok; bad ones never get here
				if (frame_ok) begin
					next_cmd_q = rx_frame;
					next_state = EXECUTE;
				end
			end
			EXECUTE: begin
				next_state = WAIT_FRAME;
				next_resp  = '0; // Writes and errors answer zero
				case (cmd_q.cmd)
					CMD_CHECK: begin
						// Echo payload, mark top nibble
						next_resp = {CHECK_TOP, CHECK_FLIP, cmd_q.addr, cmd_q.data};
					end
					CMD_RD_CFG: begin
						// Answer leaves in the host's next frame
						next_resp = {cmd_q.cmd, cmd_q.addr, config_out[cmd_q.addr]};
					end
					CMD_WR_CFG: begin
						// Data of this very frame, at its address field
						next_cfg[cmd_q.addr] = cmd_q.data;
					end
					CMD_RD_STAT: begin
						// Only one status register exists here
						if (is_stat) begin
							next_resp = {cmd_q.cmd, cmd_q.addr, status_out};
						end else begin
							decode_err = 1'b1;
						end
					end
					CMD_WR_STAT: begin
						if (!is_stat) begin
							decode_err = 1'b1;
						end else if (self_test) begin
							next_status = cmd_q.data;
						end else begin
							// Writing zero clears, writing one keeps
							next_status = status_out & cmd_q.data;
						end
					end
					CMD_RD_CTL: begin
						// Answer leaves in the host's next frame
						next_resp = {cmd_q.cmd, cmd_q.addr, control_out[cmd_q.addr]};
					end
					CMD_WR_CTL: begin
						// Writing control 0 bit 0 also sets self-test to the written value
						next_ctl[cmd_q.addr] = cmd_q.data;
					end
					CMD_CHK_RESP: begin
						// Response code: accepted, no effect
					end
					default: begin
						decode_err = 1'b1;
					end
				endcase
			end
			default: begin
				// Unreachable with two states, kept as a safe exit
				next_state = WAIT_FRAME;
			end
		endcase
		// Hardware sets come after the host write, so a set wins.
		// In self-test the fault inputs are held off so a written
		// pattern can be read back unchanged.
		if (!self_test) begin
			next_status = next_status | (fault_in & FAULT_MASK);
		end
		// Link errors flag even in self-test, so a bad frame is never lost
		if (frame_bad || decode_err) begin
			next_status[STAT_SERIAL] = 1'b1;
		end
		// Outside self-test the summary follows bits 6:0 and stays until the host clears it
		if (!self_test && (|(next_status & ~(8'h01 << STAT_ANY)))) begin
			next_status[STAT_ANY] = 1'b1;
		end
	end

	// Register banks and decoder state
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= WAIT_FRAME;
			cmd_q       <= '0;
			resp        <= '0;
			config_out  <= {NUM_REGS{BANK_RESET}};
			control_out <= {NUM_REGS{BANK_RESET}};
			status_out  <= STATUS_RESET;
		end else begin
			state       <= next_state;
			cmd_q       <= next_cmd_q;
			resp        <= next_resp;
			config_out  <= next_cfg;
			control_out <= next_ctl;
			status_out  <= next_status;
		end
	end

	// Checks below lean on the host pacing: frames end at least eight
	// cycles apart, so a frame ending never meets an execution step.
	// Sequences are joined to plain conditions by fusion, never by and.
	// Execution of one command code
	sequence exec_cmd(logic [CMD_W-1:0] c);
		state == EXECUTE && cmd_q.cmd == c;
	endsequence

	// A whole frame followed by its execution
	sequence frame_then_exec;
		frame_ok && state == WAIT_FRAME ##1 state == EXECUTE;
	endsequence

	status_reset_a: assert property (@(posedge clk)
		rst |=> status_out == STATUS_RESET && control_out == '0)
		else $error("status not cleared by reset");

	bank_on_rise_a: assert property (@(posedge clk) disable iff (rst)
		!$stable(config_out) || !$stable(control_out) |-> $past(state) == EXECUTE)
		else $error("register changed outside execution");

	frame_exec_a: assert property (@(posedge clk) disable iff (rst)
		frame_ok && state == WAIT_FRAME |=> state == EXECUTE ##1 state == WAIT_FRAME)
		else $error("received frame not executed");

	write_cfg_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_WR_CFG) |=> config_out[$past(cmd_q.addr)] == $past(cmd_q.data))
		else $error("configuration write lost");

	check_echo_a: assert property (@(posedge clk) disable iff (rst)
		frame_then_exec ##0 cmd_q.cmd == CMD_CHECK
		|=> resp == {CHECK_TOP, CHECK_FLIP, $past(cmd_q.addr), $past(cmd_q.data)})
		else $error("integrity check answer wrong");

	read_stat_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_RD_STAT) ##0 is_stat |=> resp[DATA_W-1:0] == $past(status_out))
		else $error("status read answer wrong");

	serial_err_a: assert property (@(posedge clk) disable iff (rst)
		frame_bad |=> status_out[STAT_SERIAL] ##1 status_out[STAT_SERIAL])
		else $error("bad frame did not flag serial error");

	invalid_cmd_a: assert property (@(posedge clk) disable iff (rst)
		state == EXECUTE && cmd_q.cmd[CMD_W-1]
		|=> $stable(config_out) && $stable(control_out) && status_out[STAT_SERIAL])
		else $error("invalid command not rejected");

	clear_only_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_WR_STAT) ##0 (is_stat && !self_test && !cmd_q.data[STAT_SERIAL]
		&& !frame_bad) |=> !status_out[STAT_SERIAL])
		else $error("status write did not clear serial error");

	// Reset default of the configuration bank and the answer word
	config_reset_a: assert property (@(posedge clk)
		rst |=> config_out == {NUM_REGS{BANK_RESET}} && resp == '0)
		else $error("configuration bank not at default after reset");

	write_ctl_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_WR_CTL) |=> control_out[$past(cmd_q.addr)] == $past(cmd_q.data))
		else $error("control write lost");

	// Read answers carry command, address and the value read
	read_cfg_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_RD_CFG)
		|=> resp == {CMD_RD_CFG, $past(cmd_q.addr), $past(config_out[cmd_q.addr])})
		else $error("configuration read answer wrong");

	read_ctl_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_RD_CTL)
		|=> resp == {CMD_RD_CTL, $past(cmd_q.addr), $past(control_out[cmd_q.addr])})
		else $error("control read answer wrong");

	// Writes, the response code and unknown codes answer zero
	sequence silent_cmd;
		state == EXECUTE && (cmd_q.cmd == CMD_WR_CFG || cmd_q.cmd == CMD_WR_STAT
			|| cmd_q.cmd == CMD_WR_CTL || cmd_q.cmd == CMD_CHK_RESP || cmd_q.cmd[CMD_W-1]);
	endsequence

	// Status bank access at an address that holds no register
	sequence stat_miss;
		state == EXECUTE && !is_stat
			&& (cmd_q.cmd == CMD_RD_STAT || cmd_q.cmd == CMD_WR_STAT);
	endsequence

	no_answer_a: assert property (@(posedge clk) disable iff (rst)
		silent_cmd |=> resp == '0)
		else $error("write or refused command left an answer");

	bad_addr_a: assert property (@(posedge clk) disable iff (rst)
		stat_miss |=> resp == '0 && status_out[STAT_SERIAL] && $stable(config_out)
			&& $stable(control_out))
		else $error("missing status address not refused");

	bad_frame_keep_a: assert property (@(posedge clk) disable iff (rst)
		frame_bad |=> $stable(config_out) && $stable(control_out))
		else $error("frame of wrong length changed a register");

	// Status register: faults, summary and self-test
	self_test_wr_a: assert property (@(posedge clk) disable iff (rst)
		exec_cmd(CMD_WR_STAT) ##0 (is_stat && self_test && !frame_bad)
		|=> status_out == $past(cmd_q.data))
		else $error("self-test status write not taken as written");

	self_test_mask_a: assert property (@(posedge clk) disable iff (rst)
		self_test && state == WAIT_FRAME && !frame_bad |=> $stable(status_out))
		else $error("status moved while self-test held it");

	fault_sticky_a: assert property (@(posedge clk) disable iff (rst)
		!self_test && |(fault_in & FAULT_MASK)
		|=> (status_out & $past(fault_in & FAULT_MASK)) == $past(fault_in & FAULT_MASK))
		else $error("fault level did not latch in status");

	fault_summary_a: assert property (@(posedge clk) disable iff (rst)
		!$past(self_test) && |status_out[STAT_ANY-1:0] |-> status_out[STAT_ANY])
		else $error("any-fault summary bit missing");

	sticky_status_a: assert property (@(posedge clk) disable iff (rst)
		state == WAIT_FRAME |=> (status_out | $past(status_out)) == status_out)
		else $error("status bit cleared without a host write");
endmodule : spi_command_regs

//--- spi_host_model.sv
// Host-side serial master model that drives frames into the register block
`timescale 1ns/1ns
module spi_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      frame_select_n,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	// Idle levels: serial clock low, select high
	initial begin
		sclk           = 1'b0;
		frame_select_n = 1'b1;
		si             = 1'b0;
	end

	// All pin moves land on falling system clock edges, 4 edges per half period
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// One frame with a chosen pulse count; returns the word shifted out
	task automatic xfer(input logic [15:0] w, input int pulses, output logic [15:0] r);
		r = 16'h0000;
		frame_select_n = 1'b0;
		tick(4); // Clock stays low around select edges
		for (int i = 0; i < pulses; i++) begin
			si = (i < 16) ? w[15-i] : ~si;
			tick(4);
			// Undriven output is read as noise, never as a held value
			r = {r[14:0], so_oe ? so_out : ~so_out};
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
		tick(4);
		frame_select_n = 1'b1;
		si = ~si; // Released data line does not keep its last level
		tick(10); // Gap lets the decoder finish before the next frame
	endtask : xfer
endmodule : spi_host_model

//--- tb_top.sv
// Self-checking bench for the serial command register block
`timescale 1ns/1ns
module tb_top;
	import spi_cmd_pkg::*;
	logic                            clk;             // System clock
	logic                            rst;             // Synchronous reset
	logic                            sclk;            // Link clock from host
	logic                            frame_select_n;  // Frame select from host
	logic                            si;              // Serial data to device
	logic                            so_out;          // Serial data from device
	logic                            so_oe;           // Device drives output
	logic [DATA_W-1:0]               fault_in;        // Hardware fault levels
	logic [DATA_W-1:0]               status_out;      // Status register
	logic [NUM_REGS-1:0][DATA_W-1:0] config_out;      // Configuration bank
	logic [NUM_REGS-1:0][DATA_W-1:0] control_out;     // Control bank
	logic [DATA_W-1:0]               exp_cfg [NUM_REGS]; // Expected configuration
	logic [DATA_W-1:0]               exp_ctl [NUM_REGS]; // Expected control
	logic [DATA_W-1:0]               exp_stat;        // Expected status
	logic [15:0]                     exp_ans;         // Answer due next frame
	logic [15:0]                     got;             // Answer seen
	bit                              ans_known;       // Answer is predictable
	int                              mismatches;      // Failed comparisons
	int                              samples_checked; // All comparisons

	spi_command_regs i_dut (.clk(clk), .rst(rst), .sclk(sclk),
		.frame_select_n(frame_select_n), .si(si), .fault_in(fault_in), .so_out(so_out),
		.so_oe(so_oe), .config_out(config_out), .control_out(control_out),
		.status_out(status_out));

	spi_host_model i_host (.clk(clk), .sclk(sclk), .frame_select_n(frame_select_n),
		.si(si), .so_out(so_out), .so_oe(so_oe));

	// 10 MHz system clock
	always #50 clk = ~clk;

	// Compare one value and count it
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// Self-test enable as the bench expects it
	function automatic logic self_test();
		return exp_ctl[SELF_TEST_ADDR][SELF_TEST_BIT];
	endfunction : self_test

	// Fault summary follows the low bits outside self-test
	function automatic void summarize();
		if (!self_test() && |exp_stat[6:0]) exp_stat[STAT_ANY] = 1'b1;
	endfunction : summarize

	// All registers and the idle output against the expectation
	task automatic check_regs();
		for (int i = 0; i < NUM_REGS; i++) begin
			check("config", 16'(config_out[i]), 16'(exp_cfg[i]));
			check("control", 16'(control_out[i]), 16'(exp_ctl[i]));
		end
		check("status", 16'(status_out), 16'(exp_stat));
		check("so enable", 16'(so_oe), 16'h0000);
	endtask : check_regs

	// One frame, its answer check and the expected effect
	task automatic send(input logic [15:0] w, input int pulses = 16);
		logic [3:0] c;
		logic [3:0] a;
		logic       ok;
		c = w[15:12];
		a = w[11:8];
		i_host.xfer(w, pulses, got);
		if (ans_known && pulses == 16) check("answer", got, exp_ans);
		ans_known = (pulses == 16); // A dropped frame leaves the answer open
		exp_ans = 16'h0000;
		ok = pulses == 16 && c < 4'h8;
		if ((c == CMD_RD_STAT || c == CMD_WR_STAT) && a != STATUS_ADDR) ok = 1'b0;
		if (!ok) exp_stat[STAT_SERIAL] = 1'b1;
		else case (c)
			CMD_CHECK:   exp_ans = {CHECK_TOP, CHECK_FLIP, w[11:0]};
			CMD_RD_CFG:  exp_ans = {c, a, exp_cfg[a]};
			CMD_WR_CFG:  exp_cfg[a] = w[7:0];
			CMD_RD_STAT: exp_ans = {c, a, exp_stat};
			CMD_WR_STAT: exp_stat = self_test() ? w[7:0] : exp_stat & w[7:0];
			CMD_RD_CTL:  exp_ans = {c, a, exp_ctl[a]};
			CMD_WR_CTL:  exp_ctl[a] = w[7:0];
			default: ;
		endcase
		summarize();
		check_regs();
	endtask : send

	// Hold fault levels for a few cycles; sticky outside self-test
	task automatic pulse_fault(input logic [7:0] f);
		fault_in = f;
		repeat (3) @(negedge clk);
		fault_in = 8'h00;
		repeat (4) @(negedge clk);
		if (!self_test()) exp_stat = exp_stat | (f & FAULT_MASK);
		summarize();
		check_regs();
	endtask : pulse_fault

	// Watchdog sized well beyond the roughly 1 ms the tests take
	initial begin
		#5_000_000;
		mismatches++;
		wrap_up();
	end

	// Main sequence
	initial begin
		logic [3:0] a;
		logic [7:0] d;
		clk = 1'b0;
		rst = 1'b1;
		fault_in = 8'h00;
		void'($urandom(16));
		foreach (exp_cfg[i]) exp_cfg[i] = BANK_RESET;
		foreach (exp_ctl[i]) exp_ctl[i] = BANK_RESET;
		exp_stat = STATUS_RESET;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		check_regs();
		// Random writes and read-backs, back to back
		for (int n = 0; n < 12; n++) begin
			a = 4'($urandom);
			d = 8'($urandom);
			send({CMD_WR_CFG, a, d});
			send({CMD_RD_CFG, a, 8'($urandom)});
			a = 4'($urandom_range(15, 1)); // Control 0 holds the self-test bit
			send({CMD_WR_CTL, a, d ^ 8'h5A});
			send({CMD_RD_CTL, a, 8'h00});
		end
		// Echo at both payload extremes, then the no-op response code
		send({CMD_CHECK, 12'h000});
		send({CMD_CHECK, 12'hFFF});
		send({CMD_CHECK, 12'($urandom)});
		send({CMD_CHK_RESP, 12'($urandom)});
		// Short and long frames are dropped and flagged
		send({CMD_WR_CFG, 4'h3, 8'hA5}, 15);
		send({CMD_WR_CFG, 4'h3, 8'h5A}, 17);
		send({CMD_RD_STAT, STATUS_ADDR, 8'h00});
		send({CMD_WR_STAT, STATUS_ADDR, 8'h00});
		// Undefined codes and a missing status address
		for (int c = 8; c < 16; c++) send({4'(c), 4'($urandom), 8'($urandom)});
		send({CMD_WR_STAT, 4'h2, 8'h00});
		send({CMD_RD_STAT, 4'h5, 8'h00});
		send({CMD_RD_STAT, STATUS_ADDR, 8'h00});
		send({CMD_WR_STAT, STATUS_ADDR, 8'h00});
		// Faults latch; writing ones cannot set, zeros clear
		pulse_fault(8'h88);
		pulse_fault(8'($urandom) | 8'h01);
		send({CMD_WR_STAT, STATUS_ADDR, 8'hFF});
		send({CMD_WR_STAT, STATUS_ADDR, 8'h00});
		// Self-test lets any value in and masks fault inputs
		send({CMD_WR_CTL, SELF_TEST_ADDR, 8'h01});
		send({CMD_WR_STAT, STATUS_ADDR, 8'($urandom)});
		pulse_fault(8'h77);
		send({CMD_RD_STAT, STATUS_ADDR, 8'h00});
		send({CMD_WR_CTL, SELF_TEST_ADDR, 8'h00});
		send({CMD_WR_STAT, STATUS_ADDR, 8'h00});
		send({CMD_CHECK, 12'h000});
		wrap_up();
	end
endmodule : tb_top
